// File: bench/meas_src.sv
// Upstream measurement stage model
`timescale 1ns/1ps
module meas_src (
    input wire clk_sys,
    input wire [6:0] level,
    output reg [6:0] residual_fundamental_rms = 7'h00
);
    // new value once a clock, like a stage output
    always @(posedge clk_sys) begin
        residual_fundamental_rms <= level;
    end
endmodule

// File: bench/resid_ov_asserts.sv
// Port checker of the residual overvoltage block
`timescale 1ns/1ps
module resid_ov_asserts (
    input wire clk_sys,
    input wire sys_rst,
    input wire [6:0] residual_fundamental_rms,
    input wire block_input,
    input wire general_start_out,
    input wire general_trip_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_trip_has_start: assert property (general_trip_out |-> general_start_out)
        else $error("trip without start");
    a_trip_after_start: assert property ($rose(general_trip_out) |-> $past(general_start_out))
        else $error("trip before start");
    a_block_no_start: assert property (block_input [*6] |-> !general_start_out)
        else $error("start while blocked");
    a_block_no_trip: assert property (block_input [*6] |-> !general_trip_out)
        else $error("trip while blocked");
    // Pickup never goes below 2, so 2 or less can never start
    a_low_meas_quiet: assert property ((residual_fundamental_rms <= 7'h02) [*6] |-> !general_start_out)
        else $error("start at low measurement");
    a_drop_together: assert property ($fell(general_start_out) |-> !general_trip_out)
        else $error("trip outlives start");
    a_start_cause: assert property ($rose(general_start_out) |->
        $past(residual_fundamental_rms, 3) > 7'h02 && !$past(block_input, 3))
        else $error("start without cause");
    a_reset_quiet: assert property ($past(sys_rst) |-> !general_start_out && !general_trip_out)
        else $error("output active after reset");
endmodule

// File: bench/resid_ov_tb_top.sv
// Self-checking bench of the residual overvoltage block
`timescale 1ns/1ps
module resid_ov_tb_top;
    reg clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, block_input = 1'b0, err_q;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, q;
    reg [3:0] pstrb = 4'h0;
    reg [6:0] level = 7'h00;
    wire pready, pslverr, general_start_out, general_trip_out;
    wire [31:0] prdata;
    wire [6:0] residual_fundamental_rms;
    integer num_errors = 0, n_compared = 0, n;
    always #4 clk_sys = ~clk_sys;
    // Ten cycles per tick keeps millisecond delays short
    resid_ov #(.TICK_CYCLES(10)) i_resid_ov (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .residual_fundamental_rms(residual_fundamental_rms), .block_input(block_input),
        .general_start_out(general_start_out), .general_trip_out(general_trip_out));
    meas_src i_meas_src (.clk_sys(clk_sys), .level(level), .residual_fundamental_rms(residual_fundamental_rms));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tally_and_finish;
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        i = 1;
        while (pready !== 1'b1 && i < 16) begin
            @(posedge clk_sys);
            i++;
        end
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(pready, 1);
            tally_and_finish;
        end
    endtask
    task wt(input t);
        n = 0;
        while ((t ? general_trip_out : general_start_out) !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 3000) begin
            chk(0, 1);
            tally_and_finish;
        end
    endtask
    task t_regs;
        apb(0, 12'h000, 0); chk(q, 1);
        apb(0, 12'h004, 0); chk(q, 32'h1e);
        apb(0, 12'h008, 0); chk(q, 32'h64);
        apb(1, 12'h004, 32'h1); apb(0, 12'h004, 0); chk(q, 32'h2);
        apb(1, 12'h004, 32'h3d); apb(0, 12'h004, 0); chk(q, 32'h3c);
        apb(1, 12'h008, 32'hffff); apb(0, 12'h008, 0); chk(q, 32'hea60);
        apb(0, 12'h0f0, 0); chk({q[30:0], err_q}, 1);
    endtask
    task t_trip;
        apb(1, 12'h004, 32'h0a); apb(1, 12'h008, 32'h5);
        level <= 7'h14;
        wt(0); wt(1); chk(n >= 40 && n <= 62, 1);
        apb(0, 12'h00c, 0); chk(q, 32'h14);
        apb(0, 12'h010, 0); chk(q, 32'h3);
        // Equal to pickup is not above it
        level <= 7'h0a;
        repeat (8) @(posedge clk_sys);
        chk({general_start_out, general_trip_out}, 0);
        apb(1, 12'h008, 32'h0);
        level <= 7'h14;
        wt(0); wt(1); chk(n <= 2, 1);
    endtask
    task t_only_off_block;
        apb(1, 12'h000, 32'h3);
        repeat (80) @(posedge clk_sys);
        chk({general_start_out, general_trip_out}, 2'b10);
        apb(1, 12'h000, 32'h0);
        repeat (8) @(posedge clk_sys);
        chk(general_start_out, 0);
        apb(1, 12'h000, 32'h1);
        block_input <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk({general_start_out, general_trip_out}, 0);
        block_input <= 1'b0;
        wt(0); wt(1); chk(general_start_out, 1);
        level <= 7'h00;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs;
        t_trip;
        t_only_off_block;
        tally_and_finish;
    end
endmodule
bind resid_ov resid_ov_asserts i_resid_ov_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .residual_fundamental_rms(residual_fundamental_rms), .block_input(block_input),
    .general_start_out(general_start_out), .general_trip_out(general_trip_out));

// File: design/ms_tick.v
// Millisecond tick generator
`timescale 1ns/1ps
module ms_tick #(
    parameter CYCLES = 125000
) (
    input wire clk_sys,
    input wire sys_rst,
    output reg tick_r
);
    reg [16:0] cnt_r;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else if (cnt_r == CYCLES[16:0] - 17'h00001) begin
            cnt_r <= 17'h00000;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end
endmodule

// File: design/resid_ov.v
// Residual definite-time overvoltage function with APB registers
// Notes on behaviour
// - Measure residual voltage fundamental RMS input
// - Start while measurement exceeds pickup; time
// - Pickup percent 2 to 60, default 30
// - Delay 0 to 60000 ms, default 100
// - Operation Off suppresses start and trip
// - Start-only setting withholds the trip
// - Decision combines flags with settings
// - External block input disables the function
// - General start and trip outputs
// - Start-only zero allows trip generation
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "resid_ov_defs.vh"
module resid_ov #(
    parameter TICK_CYCLES = `ROV_TICK_CYCLES
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [6:0] residual_fundamental_rms,
    input wire block_input,
    output reg general_start_out,
    output reg general_trip_out
);
    // ----------------------------------------
    // Settings registers and internal state
    // ----------------------------------------
    reg operation_setting_r;
    reg start_only_setting_r;
    reg [6:0] pickup_level_setting_r;
    reg [15:0] delay_setting_r;
    reg [6:0] meas_s1_r;
    reg [6:0] meas_r;
    reg blk_s1_r;
    reg blk_r;
    reg start_flag;
    reg trip_flag;
    reg [15:0] elapsed_r;
    wire tick;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire enabled;
    wire over;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `ROV_CTRL_OFF) || (a == `ROV_PICKUP_OFF) || (a == `ROV_DELAY_OFF) ||
                        (a == `ROV_MEAS_OFF) || (a == `ROV_STATUS_OFF);
        end
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign pready = 1'b1;
    assign addr_ok = is_mapped(paddr);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_en = psel & ~penable & ~pwrite;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            operation_setting_r <= `ROV_OPER_RST;
            start_only_setting_r <= `ROV_SONLY_RST;
            pickup_level_setting_r <= `ROV_PICKUP_RST;
            delay_setting_r <= `ROV_DELAY_RST;
        end else if (wr_en) begin
            if (paddr == `ROV_CTRL_OFF && pstrb[0]) begin
                operation_setting_r <= pwdata[`ROV_CTRL_OPER_BIT];
                start_only_setting_r <= pwdata[`ROV_CTRL_SONLY_BIT];
            end
            if (paddr == `ROV_PICKUP_OFF && pstrb[0]) begin
                if (pwdata[6:0] < `ROV_PICKUP_MIN)
                    pickup_level_setting_r <= `ROV_PICKUP_MIN;
                else if (pwdata[6:0] > `ROV_PICKUP_MAX || pwdata[31:7] != 25'h0000000)
                    pickup_level_setting_r <= `ROV_PICKUP_MAX;
                else
                    pickup_level_setting_r <= pwdata[6:0];
            end
            if (paddr == `ROV_DELAY_OFF && pstrb[1:0] == 2'b11) begin
                if (pwdata[15:0] > `ROV_DELAY_MAX || pwdata[31:16] != 16'h0000)
                    delay_setting_r <= `ROV_DELAY_MAX;
                else
                    delay_setting_r <= pwdata[15:0];
            end
        end
    end

    // Read data latched in setup so it is stable through access
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `ROV_CTRL_OFF: prdata <= {30'h00000000, start_only_setting_r, operation_setting_r};
                `ROV_PICKUP_OFF: prdata <= {25'h0000000, pickup_level_setting_r};
                `ROV_DELAY_OFF: prdata <= {16'h0000, delay_setting_r};
                `ROV_MEAS_OFF: prdata <= {25'h0000000, meas_r};
                `ROV_STATUS_OFF: prdata <= {29'h00000000, blk_r, trip_flag, start_flag};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // sample measured residual RMS
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            meas_s1_r <= 7'h00;
            meas_r <= 7'h00;
            blk_s1_r <= 1'b0;
            blk_r <= 1'b0;
        end else begin
            meas_s1_r <= residual_fundamental_rms;
            meas_r <= meas_s1_r;
            blk_s1_r <= block_input;
            blk_r <= blk_s1_r;
        end
    end

    // ----------------------------------------
    // Characteristic and timer
    // ----------------------------------------
    // millisecond time base
    ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick_r(tick)
    );

    assign enabled = operation_setting_r & ~blk_r;
    assign over = meas_r > pickup_level_setting_r;

    // Bits of a multibit bus may skew through the synchroniser; nothing absorbs it, start_flag sets on the first cycle that over is true
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            start_flag <= 1'b0;
            trip_flag <= 1'b0;
            elapsed_r <= 16'h0000;
        end else if (!(enabled && over)) begin
            start_flag <= 1'b0;
            trip_flag <= 1'b0;
            elapsed_r <= 16'h0000;
        end else begin
            start_flag <= 1'b1;
            // trip once delay elapsed
            // Trip waits for start, so a zero delay still trips one cycle after start
            if (start_flag && elapsed_r >= delay_setting_r)
                trip_flag <= 1'b1;
            if (tick && start_flag && elapsed_r != 16'hffff)
                elapsed_r <= elapsed_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // Decision logic
    // ----------------------------------------
    // combine flags and settings
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            general_start_out <= 1'b0;
            general_trip_out <= 1'b0;
        end else begin
            general_start_out <= start_flag & enabled & over;
            general_trip_out <= trip_flag & ~start_only_setting_r & enabled & over;
        end
    end
endmodule

// File: design/resid_ov_defs.vh
// Constants of the residual overvoltage function: offsets, fields, resets, timing
`ifndef RESID_OV_DEFS_VH
`define RESID_OV_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ROV_CTRL_OFF 12'h000
`define ROV_PICKUP_OFF 12'h004
`define ROV_DELAY_OFF 12'h008
`define ROV_MEAS_OFF 12'h00c
`define ROV_STATUS_OFF 12'h010
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ROV_CTRL_OPER_BIT 0
`define ROV_CTRL_SONLY_BIT 1
`define ROV_STAT_START_BIT 0
`define ROV_STAT_TRIP_BIT 1
`define ROV_STAT_BLOCK_BIT 2
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define ROV_OPER_RST 1'b1
`define ROV_SONLY_RST 1'b0
`define ROV_PICKUP_RST 7'h1e
`define ROV_PICKUP_MIN 7'h02
`define ROV_PICKUP_MAX 7'h3c
`define ROV_DELAY_RST 16'h0064
`define ROV_DELAY_MAX 16'hea60
// ----------------------------------------
// Timing
// ----------------------------------------
`define ROV_CLK_HZ 125000000
`define ROV_TICK_MS 1
`define ROV_TICK_CYCLES (`ROV_CLK_HZ / 1000 * `ROV_TICK_MS)
`endif
